// ==== core/rpbwm_pkg.sv ====
// Package for the right port bus width matcher controller
package rpbwm_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned PORT_W = 36;
    localparam int unsigned LANE_W = 9;
    localparam int unsigned RAM_AW = 15;
    // Register offsets (byte addresses)
    localparam logic [11:0] OFF_CFG = 12'h000;
    localparam logic [11:0] OFF_ADDR = 12'h004;
    localparam logic [11:0] OFF_WDLO = 12'h008;
    localparam logic [11:0] OFF_WDHI = 12'h00c;
    localparam logic [11:0] OFF_CMD = 12'h010;
    localparam logic [11:0] OFF_STAT = 12'h014;
    localparam logic [11:0] OFF_RDLO = 12'h018;
    localparam logic [11:0] OFF_RDHI = 12'h01c;
    // Config and command field positions
    localparam int unsigned CFG_NARROW = 0;
    localparam int unsigned CFG_SIZE = 1;
    localparam int unsigned CMD_GO = 0;
    localparam int unsigned CMD_WRITE = 1;
    localparam int unsigned CMD_TOKEN = 2;
    localparam logic [1:0] CFG_RESET = 2'h0;
    // Access timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned ACCESS_NS = 20;
    localparam int unsigned ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RECOVER_NS = 10;
    localparam int unsigned RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {RPBWM_IDLE, RPBWM_ACCESS, RPBWM_RECOVER} rpbwm_state_e;
    typedef enum logic [1:0] {MODE_X36, MODE_OFF, MODE_X18, MODE_X9} rpbwm_mode_e;

    function automatic rpbwm_mode_e rpbwm_mode(input logic narrow, input logic size);
        rpbwm_mode = narrow ? (size ? MODE_X9 : MODE_X18) : (size ? MODE_OFF : MODE_X36);
    endfunction : rpbwm_mode
endpackage : rpbwm_pkg

// ==== core/rpbwm_host.sv ====
// Host controller driving the right port of a bus-matched dual-port RAM
module rpbwm_host
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [rpbwm_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [rpbwm_pkg::DATA_W-1:0] pwdata_i,
    output logic [rpbwm_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic narrow_mode_enable_o,
    output logic size_select_o,
    output logic word_lane_select_o,
    output logic byte_lane_select_o,
    output logic [rpbwm_pkg::RAM_AW-1:0] addr_o,
    output logic chip_en_n_o,
    output logic token_latch_select_n_o,
    output logic rw_o,
    output logic out_en_n_o,
    input wire logic [rpbwm_pkg::PORT_W-1:0] io_i,
    output logic [rpbwm_pkg::PORT_W-1:0] io_o,
    output logic [rpbwm_pkg::PORT_W-1:0] io_oe_o
);
    import rpbwm_pkg::*;

    rpbwm_state_e state_q;
    logic [1:0] cfg_q;
    logic [RAM_AW+1:0] addr_q;
    logic [PORT_W-1:0] wdata_q;
    logic [PORT_W-1:0] rdata_q;
    logic wr_q;
    logic tok_q;
    logic busy_q;
    logic done_q;
    logic [3:0] cnt_q;
    rpbwm_mode_e mode;
    logic bus_wr;
    logic bus_rd;
    logic go;
    logic lane_word;
    logic lane_byte;

    assign mode = rpbwm_mode(cfg_q[CFG_NARROW], cfg_q[CFG_SIZE]);
    assign bus_wr = psel_i && penable_i && pwrite_i;
    assign bus_rd = psel_i && !penable_i && !pwrite_i;
    assign go = bus_wr && paddr_i == OFF_CMD && pwdata_i[CMD_GO] && state_q == RPBWM_IDLE;
    assign lane_word = (mode == MODE_X18 || mode == MODE_X9) && addr_q[RAM_AW];
    assign lane_byte = mode == MODE_X9 && addr_q[RAM_AW+1];

    // Slave answers in the access phase, zero wait states
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pready_o <= 1'b0;
        else
            pready_o <= psel_i && !penable_i;
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pslverr_o <= 1'b0;
        else
            pslverr_o <= psel_i && !penable_i && paddr_i > OFF_RDHI;
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            prdata_o <= '0;
        end
        else if (bus_rd)
        begin
            case (paddr_i)
                OFF_CFG: prdata_o <= {30'h0, cfg_q};
                OFF_ADDR: prdata_o <= {{(DATA_W-RAM_AW-2){1'b0}}, addr_q};
                OFF_WDLO: prdata_o <= wdata_q[31:0];
                OFF_WDHI: prdata_o <= {28'h0, wdata_q[35:32]};
                OFF_STAT: prdata_o <= {30'h0, done_q, busy_q};
                OFF_RDLO: prdata_o <= rdata_q[31:0];
                OFF_RDHI: prdata_o <= {28'h0, rdata_q[35:32]};
                default: prdata_o <= '0;
            endcase
        end
    end

    // Width settings must stay static, so they only change while idle
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            cfg_q <= CFG_RESET;
        else if (bus_wr && paddr_i == OFF_CFG && state_q == RPBWM_IDLE)
            cfg_q <= pwdata_i[1:0];
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            addr_q <= '0;
            wdata_q <= '0;
        end
        else if (state_q == RPBWM_IDLE && bus_wr)
        begin
            if (paddr_i == OFF_ADDR)
                addr_q <= pwdata_i[RAM_AW+1:0];
            if (paddr_i == OFF_WDLO)
                wdata_q[31:0] <= pwdata_i;
            if (paddr_i == OFF_WDHI)
                wdata_q[35:32] <= pwdata_i[3:0];
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wr_q <= 1'b0;
            tok_q <= 1'b0;
        end
        else if (go)
        begin
            wr_q <= pwdata_i[CMD_WRITE];
            tok_q <= pwdata_i[CMD_TOKEN];
        end
    end

    // Access sequencer
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_q <= RPBWM_IDLE;
            cnt_q <= '0;
        end
        else
        begin
            case (state_q)
                RPBWM_IDLE:
                    if (go)
                    begin
                        state_q <= RPBWM_ACCESS;
                        cnt_q <= 4'(ACCESS_CYC - 1);
                    end
                RPBWM_ACCESS:
                    if (cnt_q == 4'h0)
                    begin
                        state_q <= RPBWM_RECOVER;
                        cnt_q <= 4'(RECOVER_CYC - 1);
                    end
                    else
                        cnt_q <= cnt_q - 4'h1;
                RPBWM_RECOVER:
                    if (cnt_q == 4'h0)
                        state_q <= RPBWM_IDLE;
                    else
                        cnt_q <= cnt_q - 4'h1;
                default: state_q <= RPBWM_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            busy_q <= 1'b0;
        else
            busy_q <= go || (busy_q && !(state_q == RPBWM_RECOVER && cnt_q == 4'h0));
    end

    // Completion wins over a software clear landing in the same cycle
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            done_q <= 1'b0;
        else if (state_q == RPBWM_RECOVER && cnt_q == 4'h0)
            done_q <= 1'b1;
        else if (go || (bus_wr && paddr_i == OFF_STAT && pwdata_i[1]))
            done_q <= 1'b0;
    end

    // Read data captured at the end of the access, narrow lanes returned in the low bits
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rdata_q <= '0;
        else if (state_q == RPBWM_ACCESS && cnt_q == 4'h0 && !wr_q)
        begin
            case (mode)
                MODE_X18: rdata_q <= {18'h0, io_i[17:0]};
                MODE_X9: rdata_q <= {27'h0, io_i[8:0]};
                MODE_OFF: rdata_q <= {27'h0, io_i[8:0]};
                default: rdata_q <= io_i;
            endcase
        end
    end

    // Pin drivers; ignored lane selects held low, never floating
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            narrow_mode_enable_o <= 1'b0;
            size_select_o <= 1'b0;
            word_lane_select_o <= 1'b0;
            byte_lane_select_o <= 1'b0;
            addr_o <= '0;
        end
        else
        begin
            narrow_mode_enable_o <= cfg_q[CFG_NARROW];
            size_select_o <= cfg_q[CFG_SIZE];
            addr_o <= addr_q[RAM_AW-1:0];
            word_lane_select_o <= lane_word;
            byte_lane_select_o <= lane_byte;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            chip_en_n_o <= 1'b1;
            token_latch_select_n_o <= 1'b1;
            rw_o <= 1'b1;
            out_en_n_o <= 1'b1;
        end
        else
        begin
            // Disable mode keeps chip enable active for semaphore access
            chip_en_n_o <= !(state_q == RPBWM_ACCESS && (!tok_q || mode == MODE_OFF));
            token_latch_select_n_o <= !(state_q == RPBWM_ACCESS && tok_q);
            rw_o <= !(state_q == RPBWM_ACCESS && wr_q);
            out_en_n_o <= !(state_q == RPBWM_ACCESS && !wr_q);
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            io_o <= '0;
            io_oe_o <= '0;
        end
        else
        begin
            io_o <= wdata_q;
            if (state_q == RPBWM_ACCESS && wr_q)
            begin
                case (mode)
                    MODE_X18: io_oe_o <= {18'h0, 18'h3ffff};
                    MODE_X9: io_oe_o <= {27'h0, 9'h1ff};
                    MODE_OFF: io_oe_o <= {35'h0, 1'b1};
                    default: io_oe_o <= '1;
                endcase
            end
            else
                io_oe_o <= '0;
        end
    end
endmodule : rpbwm_host

// ==== bench/rpbwm_host_chk.sv ====
// Concurrent checks on the host controller pins
module rpbwm_host_chk
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [11:0] paddr_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic narrow_mode_enable_o,
    input wire logic size_select_o,
    input wire logic word_lane_select_o,
    input wire logic byte_lane_select_o,
    input wire logic [14:0] addr_o,
    input wire logic chip_en_n_o,
    input wire logic token_latch_select_n_o,
    input wire logic rw_o,
    input wire logic [35:0] io_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    logic act;
    assign act = !chip_en_n_o || !token_latch_select_n_o;
    sequence s_open;
        $rose(act);
    endsequence
    sequence s_hold;
        act [*2] ##1 !act;
    endsequence
    property p_hold;
        s_open |-> s_hold;
    endproperty
    property p_ready;
        psel_i && !penable_i |=> pready_o;
    endproperty
    property p_err;
        psel_i && !penable_i && paddr_i > 12'h01c |=> pslverr_o;
    endproperty
    property p_narrow;
        act |-> $stable(narrow_mode_enable_o);
    endproperty
    property p_size;
        act |-> $stable(size_select_o);
    endproperty
    property p_lanes;
        act && $past(act) |-> $stable({word_lane_select_o, byte_lane_select_o, addr_o});
    endproperty
    property p_wide;
        act && !narrow_mode_enable_o |-> !word_lane_select_o && !byte_lane_select_o;
    endproperty
    property p_half;
        act && narrow_mode_enable_o && !size_select_o |-> !byte_lane_select_o;
    endproperty
    property p_oe_full;
        !rw_o && !narrow_mode_enable_o && !size_select_o |-> io_oe_o == 36'hfffffffff;
    endproperty
    property p_oe_word;
        !rw_o && narrow_mode_enable_o && !size_select_o |-> io_oe_o == 36'h00003ffff;
    endproperty
    property p_oe_byte;
        !rw_o && narrow_mode_enable_o && size_select_o |-> io_oe_o == 36'h0000001ff;
    endproperty
    property p_oe_idle;
        rw_o |-> io_oe_o == 36'h0;
    endproperty
    a_hold: assert property (p_hold) else $error("access strobe length wrong");
    a_ready: assert property (p_ready) else $error("no ready in access phase");
    a_err: assert property (p_err) else $error("no error on unmapped address");
    a_narrow: assert property (p_narrow) else $error("width select moved");
    a_size: assert property (p_size) else $error("size select moved");
    a_lanes: assert property (p_lanes) else $error("address moved in access");
    a_wide: assert property (p_wide) else $error("lane select set in wide mode");
    a_half: assert property (p_half) else $error("byte select set in word mode");
    a_oe_full: assert property (p_oe_full) else $error("wide write not on all pins");
    a_oe_word: assert property (p_oe_word) else $error("word write drives high pins");
    a_oe_byte: assert property (p_oe_byte) else $error("byte write drives high pins");
    a_oe_idle: assert property (p_oe_idle) else $error("pins driven outside a write");
endmodule : rpbwm_host_chk

bind rpbwm_host rpbwm_host_chk i_chk (.clock_i, .rstn_i, .psel_i, .penable_i, .paddr_i,
    .pready_o, .pslverr_o, .narrow_mode_enable_o, .size_select_o, .word_lane_select_o,
    .byte_lane_select_o, .addr_o, .chip_en_n_o, .token_latch_select_n_o, .rw_o, .io_oe_o);

// ==== bench/rpbwm_dev.sv ====
// Behavioural right port of the dual-port memory
module rpbwm_dev
(
    input wire logic narrow_i,
    input wire logic size_i,
    input wire logic wl_i,
    input wire logic bl_i,
    input wire logic [14:0] addr_i,
    input wire logic ce_n_i,
    input wire logic tok_n_i,
    input wire logic rw_i,
    input wire logic oe_n_i,
    input wire logic [35:0] io_i,
    output logic [35:0] io_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [35:0] mem [16] = '{default: 36'h0};
    logic [7:0] tok_q = 8'hff;
    logic [35:0] last_q = 36'h0;
    logic [35:0] wm, drv, val, cur;
    logic off, srd;
    int sh;
    always @*
    begin
        off = !narrow_i && size_i;
        sh = narrow_i ? 9 * {wl_i, bl_i & size_i} : 0;
        wm = !narrow_i ? '1 : size_i ? 36'h1ff : 36'h3ffff;
        cur = mem[addr_i[3:0]];
        srd = !tok_n_i && rw_i && !oe_n_i && (ce_n_i || off);
        val = srd ? {27'h0, {9{tok_q[addr_i[2:0]]}}} : cur >> sh;
        drv = srd ? 36'h1ff : (!ce_n_i && tok_n_i && rw_i && !oe_n_i && !off) ? wm : 36'h0;
        if (|drv)
            last_q = val;
        if (!rw_i && !tok_n_i && (ce_n_i || off))
            tok_q[addr_i[2:0]] = io_i[0];
        if (!rw_i && !ce_n_i && tok_n_i && !off)
            mem[addr_i[3:0]] = (cur & ~(wm << sh)) | ((io_i & wm) << sh);
    end
    // Released pins show the inverse of the last value, never a kind constant
    assign io_o = (val & drv) | (~last_q & ~drv);
endmodule : rpbwm_dev

// ==== bench/rpbwm_host_bench.sv ====
// Self-checking bench for the width matcher host controller
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module rpbwm_host_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rpbwm_pkg::*;
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, perr;
    logic [11:0] pa = 0;
    logic [31:0] pw = 0, prdata, prd;
    logic rdy, err, nm, sz, wl, bl, ce_n, tok_n, rw, oe_n;
    logic [14:0] a;
    logic [35:0] hio, hoe, dio, wio, r, e;
    int n_fail = 0, n_compared = 0, cyc = 0;
    always #5 clk = ~clk;
    assign wio = (hio & hoe) | (dio & ~hoe);
    rpbwm_host i_dut (.clock_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pw), .prdata_o(prdata), .pready_o(rdy),
        .pslverr_o(err), .narrow_mode_enable_o(nm), .size_select_o(sz),
        .word_lane_select_o(wl), .byte_lane_select_o(bl), .addr_o(a), .chip_en_n_o(ce_n),
        .token_latch_select_n_o(tok_n), .rw_o(rw), .out_en_n_o(oe_n), .io_i(wio),
        .io_o(hio), .io_oe_o(hoe));
    rpbwm_dev i_dev (.narrow_i(nm), .size_i(sz), .wl_i(wl), .bl_i(bl), .addr_i(a),
        .ce_n_i(ce_n), .tok_n_i(tok_n), .rw_i(rw), .oe_n_i(oe_n), .io_i(wio), .io_o(dio));
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // Request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        pa <= ad;
        pw <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        prd = prdata;
        perr = err;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic op(input logic [1:0] c, input logic [16:0] ad, input logic [2:0] cmd,
        input logic [35:0] wd);
        logic [31:0] lo;
        apb(1, OFF_CFG, {30'h0, c});
        apb(1, OFF_ADDR, {15'h0, ad});
        apb(1, OFF_WDLO, wd[31:0]);
        apb(1, OFF_WDHI, {28'h0, wd[35:32]});
        apb(1, OFF_CMD, {29'h0, cmd});
        do apb(0, OFF_STAT, 32'h0); while (prd[1] !== 1'b1);
        apb(1, OFF_STAT, 32'h2);
        apb(0, OFF_RDLO, 32'h0);
        lo = prd;
        apb(0, OFF_RDHI, 32'h0);
        r = {prd[3:0], lo};
    endtask : op
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        `CHK("reset pins", 4'hf, {ce_n, tok_n, rw, oe_n})
        `CHK("reset oe", 36'h0, hoe)
        rstn <= 1'b1;
        @(posedge clk);
        apb(0, OFF_CFG, 32'h0);
        `CHK("cfg reset", 32'h0, prd)
        apb(0, 12'h020, 32'h0);
        `CHK("unmapped", 1'b1, perr)
        $display("test reset done");
        e = 36'h987654321;
        op(2'h0, 17'h18005, 3'h3, e);
        op(2'h0, 17'h00005, 3'h1, 36'h0);
        `CHK("x36 word", e, r)
        op(2'h1, 17'h08005, 3'h3, 36'h12345);
        e = {18'h12345, e[17:0]};
        op(2'h0, 17'h00005, 3'h1, 36'h0);
        `CHK("x18 upper write", e, r)
        op(2'h1, 17'h10005, 3'h1, 36'h0);
        `CHK("x18 lower read", e[17:0], r[17:0])
        $display("test wide and word done");
        for (int i = 0; i < 4; i++)
        begin
            op(2'h3, {i[0], i[1], 15'h6}, 3'h3, {27'h0, 9'h1a0 + 9'(i)});
        end
        e = {9'h1a3, 9'h1a2, 9'h1a1, 9'h1a0};
        op(2'h0, 17'h00006, 3'h1, 36'h0);
        `CHK("x9 lanes", e, r)
        for (int i = 0; i < 4; i++)
        begin
            op(2'h3, {i[0], i[1], 15'h6}, 3'h1, 36'h0);
            `CHK("x9 read", 9'h1a0 + 9'(i), r[8:0])
        end
        $display("test byte done");
        op(2'h2, 17'h00006, 3'h3, 36'h0);
        op(2'h0, 17'h00006, 3'h1, 36'h0);
        `CHK("off mode write", e, r)
        op(2'h2, 17'h00003, 3'h7, 36'h0);
        op(2'h2, 17'h00003, 3'h5, 36'h0);
        `CHK("token taken", 1'b0, r[0])
        op(2'h0, 17'h00003, 3'h7, 36'h1);
        op(2'h0, 17'h00003, 3'h5, 36'h0);
        `CHK("token freed", 1'b1, r[0])
        $display("test token done");
        tally_and_finish();
    end
endmodule : rpbwm_host_bench
